// ### logic/asd_pkg.sv
// Purpose: Constants shared by the address-space decoder and its pointer bank
// Assumes: 8-bit core, 16-bit program and external data addresses
// Notes: Function register offsets are the byte addresses of the register space
// Functional notes
// - Program and data spaces separate, 64K each
// - Strap low: every fetch goes external
// - Strap high: 0000H-1FFFH fetched on chip
// - Strap high: 2000H-FFFFH fetched externally
// - Internal data RAM holds 256 bytes
// - Upper RAM and register space never alias
// - Direct access above 7FH hits registers
// - Indirect access above 7FH hits upper RAM
// - Stack accesses count as indirect accesses
// - Select bit 0 picks active pointer pair
// - Lock bit set: strap latched on the first edge after reset
// - Pointer high byte drives port 2 address
package asd_pkg;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned RAM_DEPTH = 256;
  localparam int unsigned RAM_AW = 8;
  // Highest on-chip program address
  localparam logic [15:0] INT_CODE_TOP = 16'h1FFF;
  // Boundary between lower RAM and the shared upper region
  localparam logic [7:0] LOWER_TOP = 8'h7F;
  // Function register offsets handled here
  localparam logic [7:0] OFS_PTR_A_LOW = 8'h82;
  localparam logic [7:0] OFS_PTR_A_HIGH = 8'h83;
  localparam logic [7:0] OFS_PTR_B_LOW = 8'h84;
  localparam logic [7:0] OFS_PTR_B_HIGH = 8'h85;
  localparam logic [7:0] OFS_PTR_SEL_CTRL = 8'hA2;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int unsigned SEL_BIT = 0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // Data access target
  typedef enum logic [1:0]
  {
    ASD_TGT_LOWER = 2'b00,
    ASD_TGT_UPPER = 2'b01,
    ASD_TGT_REG = 2'b10
  } asd_target_t;
endpackage

// ### logic/asd_pointer_pair.sv
// Purpose: One 16-bit data pointer held as a low and a high byte
// Assumes: Writes arrive as single byte strobes from the register decoder
// Notes: Both pairs are instances of this module
module asd_pointer_pair #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic lowWr,
  input wire logic highWr,
  input wire logic [7:0] wrData,
  output logic [15:0] pointer
);
  logic [7:0] low_q;
  logic [7:0] high_q;

  // Low byte register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      low_q <= RESET_VAL;
    else if (lowWr)
      low_q <= wrData;
  end

  // High byte register
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      high_q <= RESET_VAL;
    else if (highWr)
      high_q <= wrData;
  end

  assign pointer = {high_q, low_q};
endmodule

// ### logic/asd_address_space_decoder.sv
// Purpose: Steers program fetches and internal data accesses to their spaces
// Assumes: Core presents one fetch and at most one data access per cycle
// Notes: Answers are registered, so they appear one edge after the request
// Notes: Internal RAM has no reset; software must write before it reads
module asd_address_space_decoder
(
  input wire logic core_clk,
  input wire logic rst,
  // Strap and lock configuration
  input wire logic externalFetchStrap,
  input wire logic lockBitOne,
  // Program fetch request
  input wire logic fetchReq,
  input wire logic [asd_pkg::ADDR_W-1:0] fetchAddr,
  // Internal data access request
  input wire logic dataReq,
  input wire logic dataWr,
  input wire logic dataIndirect,
  input wire logic dataStack,
  input wire logic [asd_pkg::RAM_AW-1:0] dataAddr,
  input wire logic [asd_pkg::DATA_W-1:0] dataWrData,
  // Register space read data from other function registers
  input wire logic [asd_pkg::DATA_W-1:0] otherRegRdData,
  // External data move using the 16-bit pointer
  input wire logic extMoveReq,
  // Fetch answers
  output logic fetchInternal,
  output logic fetchExternal,
  output logic [asd_pkg::ADDR_W-1:0] fetchAddrOut,
  // Data answers
  output logic dataValid,
  output logic [asd_pkg::DATA_W-1:0] dataRdData,
  output logic regAccess,
  output logic regWrite,
  output logic [asd_pkg::RAM_AW-1:0] regAddr,
  output logic [asd_pkg::DATA_W-1:0] regWrData,
  output logic upperRamHit,
  // External move address
  output logic extMoveValid,
  output logic [asd_pkg::ADDR_W-1:0] extMoveAddr,
  output logic [asd_pkg::DATA_W-1:0] port2Addr,
  output logic pointerPairSelect
);
  import asd_pkg::*;

  // Internal data RAM, lower and upper halves in one array
  logic [DATA_W-1:0] ram [RAM_DEPTH];
  // Strap and pointer configuration state
  logic strapLatched_q; // Strap captured on the first edge after reset
  logic strapCaptured_q; // Capture done since last reset
  logic pointerSel_q; // Active pointer pair
  // Decode helpers
  logic effStrap; // Strap level used for steering
  logic [15:0] pointerA;
  logic [15:0] pointerB;
  logic [15:0] activePointer;
  asd_target_t target;
  logic regWrHit;
  logic [DATA_W-1:0] localRegData;
  logic localRegHit;
  // Registered fetch answers
  logic fetchInternal_q;
  logic fetchExternal_q;
  logic [ADDR_W-1:0] fetchAddr_q;
  // Registered data answers
  logic dataValid_q;
  logic [DATA_W-1:0] dataRdData_q;
  logic regAccess_q;
  logic regWrite_q;
  logic [RAM_AW-1:0] regAddr_q;
  logic [DATA_W-1:0] regWrData_q;
  logic upperRamHit_q;
  // Registered move answers
  logic extMoveValid_q;
  logic [ADDR_W-1:0] extMoveAddr_q;
  logic [DATA_W-1:0] port2Addr_q;

  // Strap capture on the first edge after reset release; a port value
  // cannot be loaded under asynchronous reset, so the catch is clocked
  // The copy is used only while the lock input is high
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      strapLatched_q <= 1'b0;
      strapCaptured_q <= 1'b0;
    end
    else if (!strapCaptured_q)
    begin
      strapLatched_q <= externalFetchStrap;
      strapCaptured_q <= 1'b1;
    end
  end

  // With the lock bit set the latched level rules until the next reset
  // Without the lock the live pin steers every cycle, so a moving strap moves fetches
  assign effStrap = (lockBitOne && strapCaptured_q) ? strapLatched_q : externalFetchStrap;

  // Fetch address copy, taken every cycle so the far side always sees it
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      fetchAddr_q <= '0;
    else
      fetchAddr_q <= fetchAddr;
  end

  // Fetch steering; program space is its own 64K space
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      fetchInternal_q <= 1'b0;
      fetchExternal_q <= 1'b0;
    end
    else if (!fetchReq)
    begin
      // Idle cycle: neither memory is strobed
      fetchInternal_q <= 1'b0;
      fetchExternal_q <= 1'b0;
    end
    else if (!effStrap)
    begin
      // Strap low: everything external
      fetchInternal_q <= 1'b0;
      fetchExternal_q <= 1'b1;
    end
    else if (fetchAddr <= INT_CODE_TOP)
    begin
      // Low program addresses stay on chip
      fetchInternal_q <= 1'b1;
      fetchExternal_q <= 1'b0;
    end
    else
    begin
      // Above the on-chip top the fetch leaves the chip
      fetchInternal_q <= 1'b0;
      fetchExternal_q <= 1'b1;
    end
  end

  // Target choice: lower region ignores mode, upper region follows it
  // Stack pushes and pops address through the stack pointer, hence indirect
  always_comb
  begin
    if (dataAddr <= LOWER_TOP)
      target = ASD_TGT_LOWER;
    else if (dataIndirect || dataStack)
      target = ASD_TGT_UPPER;
    else
      target = ASD_TGT_REG;
  end

  // Register-space write strobe shared by the local registers
  assign regWrHit = dataReq && dataWr && (target == ASD_TGT_REG);

  // Pointer select register; only bit 0 is stored, upper bits read zero
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pointerSel_q <= 1'b0;
    else if (regWrHit && dataAddr == OFS_PTR_SEL_CTRL)
      pointerSel_q <= dataWrData[SEL_BIT];
  end

  // Two pointer pairs, written through their register offsets
  asd_pointer_pair #(
    .RESET_VAL(PTR_RESET)
  ) u_pair_a (
    .core_clk(core_clk),
    .rst(rst),
    .lowWr(regWrHit && dataAddr == OFS_PTR_A_LOW),
    .highWr(regWrHit && dataAddr == OFS_PTR_A_HIGH),
    .wrData(dataWrData),
    .pointer(pointerA)
  );

  asd_pointer_pair #(
    .RESET_VAL(PTR_RESET)
  ) u_pair_b (
    .core_clk(core_clk),
    .rst(rst),
    .lowWr(regWrHit && dataAddr == OFS_PTR_B_LOW),
    .highWr(regWrHit && dataAddr == OFS_PTR_B_HIGH),
    .wrData(dataWrData),
    .pointer(pointerB)
  );

  // Active pair feeds every external move
  assign activePointer = pointerSel_q ? pointerB : pointerA;

  // Read-back of the registers held in this block
  always_comb
  begin
    localRegHit = 1'b1;
    localRegData = ZERO_BYTE;
    unique case (dataAddr)
      OFS_PTR_A_LOW: localRegData = pointerA[7:0];
      OFS_PTR_A_HIGH: localRegData = pointerA[15:8];
      OFS_PTR_B_LOW: localRegData = pointerB[7:0];
      OFS_PTR_B_HIGH: localRegData = pointerB[15:8];
      OFS_PTR_SEL_CTRL: localRegData = {7'b000_0000, pointerSel_q};
      default: localRegHit = 1'b0;
    endcase
  end

  // RAM write; register-space writes never touch RAM, so no aliasing
  // RAM holds no reset value; reads before a write return unknown data
  always_ff @(posedge core_clk)
  begin
    if (dataReq && dataWr && target != ASD_TGT_REG)
      ram[dataAddr] <= dataWrData;
  end

  // Access flags, one cycle per request, one edge after it
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dataValid_q <= 1'b0;
      regAccess_q <= 1'b0;
      regWrite_q <= 1'b0;
      upperRamHit_q <= 1'b0;
    end
    else
    begin
      dataValid_q <= dataReq;
      // Only registers held outside this block are reported outward
      regAccess_q <= dataReq && (target == ASD_TGT_REG) && !localRegHit;
      regWrite_q <= dataReq && dataWr && (target == ASD_TGT_REG) && !localRegHit;
      upperRamHit_q <= dataReq && (target == ASD_TGT_UPPER);
    end
  end

  // Address and write data copies for the outside registers; they follow
  // the inputs every cycle and mean something only with regAccess high
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      regAddr_q <= '0;
      regWrData_q <= ZERO_BYTE;
    end
    else
    begin
      regAddr_q <= dataAddr;
      regWrData_q <= dataWrData;
    end
  end

  // Read data; writes and idle cycles return zero so stale bytes never leak
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      dataRdData_q <= ZERO_BYTE;
    else if (!dataReq || dataWr)
      dataRdData_q <= ZERO_BYTE;
    else if (target != ASD_TGT_REG)
      dataRdData_q <= ram[dataAddr];
    else if (localRegHit)
      dataRdData_q <= localRegData;
    else
      dataRdData_q <= otherRegRdData;
  end

  // External move strobe and address from the active pointer
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      extMoveValid_q <= 1'b0;
      extMoveAddr_q <= '0;
    end
    else
    begin
      extMoveValid_q <= extMoveReq;
      extMoveAddr_q <= activePointer;
    end
  end

  // Upper address byte on port 2; it holds between moves, which is what the
  // pins would show while no 16-bit external cycle runs
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      port2Addr_q <= ZERO_BYTE;
    else if (extMoveReq)
      port2Addr_q <= activePointer[15:8];
  end

  // Every output comes straight from its flip-flop
  assign fetchInternal = fetchInternal_q;
  assign fetchExternal = fetchExternal_q;
  assign fetchAddrOut = fetchAddr_q;
  assign dataValid = dataValid_q;
  assign dataRdData = dataRdData_q;
  assign regAccess = regAccess_q;
  assign regWrite = regWrite_q;
  assign regAddr = regAddr_q;
  assign regWrData = regWrData_q;
  assign upperRamHit = upperRamHit_q;
  assign extMoveValid = extMoveValid_q;
  assign extMoveAddr = extMoveAddr_q;
  assign port2Addr = port2Addr_q;
  assign pointerPairSelect = pointerSel_q;
endmodule

// ### sim/asd_ext_mem_model.sv
// Purpose: Far-side memory, counts the external cycles it serves
// Assumes: One external cycle per answer pulse
// Notes: No data pins exist, so only traffic is modelled
module asd_ext_mem_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic fetchExternal,
  input wire logic extMoveValid,
  output logic [15:0] extHits
);
  // One byte per pulse from a 64K space
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      extHits <= 16'h0000;
    else if (fetchExternal || extMoveValid)
      extHits <= extHits + 16'h0001;
  end
endmodule

// ### sim/asd_dec_assertions.sv
// Purpose: Port checks for the decoder
// Assumes: Answers come one edge after the request
// Notes: Fetch checks only with the lock input low
module asd_dec_assertions (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic externalFetchStrap,
  input wire logic lockBitOne,
  input wire logic fetchReq,
  input wire logic [15:0] fetchAddr,
  input wire logic dataReq,
  input wire logic dataWr,
  input wire logic dataIndirect,
  input wire logic dataStack,
  input wire logic [7:0] dataAddr,
  input wire logic [7:0] dataWrData,
  input wire logic extMoveReq,
  input wire logic fetchInternal,
  input wire logic fetchExternal,
  input wire logic dataValid,
  input wire logic regAccess,
  input wire logic upperRamHit,
  input wire logic extMoveValid,
  input wire logic [15:0] extMoveAddr,
  input wire logic [7:0] port2Addr,
  input wire logic pointerPairSelect
);
  import asd_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Direct access above the lower region
  wire logic dirHi = dataReq && !dataIndirect && !dataStack && dataAddr > LOWER_TOP;
  // Registers kept inside the block are not reported outward
  wire logic localReg = dataAddr inside {[8'h82:8'h85], 8'hA2};
  wire logic selWr = dirHi && dataWr && dataAddr == OFS_PTR_SEL_CTRL;
  wire logic liveFetch = fetchReq && !lockBitOne;
  sequence sSelWr;
    selWr;
  endsequence
  AST_FETCH_LOW: assert property (liveFetch && !externalFetchStrap |=> fetchExternal && !fetchInternal)
    else $error("strap low fetch not external");
  AST_FETCH_INT: assert property (liveFetch && externalFetchStrap && fetchAddr <= INT_CODE_TOP |=> fetchInternal)
    else $error("low code fetch not internal");
  AST_FETCH_EXT: assert property (liveFetch && externalFetchStrap && fetchAddr > INT_CODE_TOP |=> fetchExternal)
    else $error("high code fetch not external");
  AST_REG_DIR: assert property (dirHi && !localReg |=> regAccess && !upperRamHit)
    else $error("direct access missed registers");
  AST_UPPER_IND: assert property (dataReq && (dataIndirect || dataStack) && dataAddr[7] |=> upperRamHit && !regAccess)
    else $error("indirect access missed upper RAM");
  AST_LOWER: assert property (dataReq && !dataAddr[7] |=> dataValid && !regAccess && !upperRamHit)
    else $error("lower access misrouted");
  AST_MOVE: assert property (extMoveReq |=> extMoveValid && port2Addr == extMoveAddr[15:8])
    else $error("port 2 byte wrong on move");
  AST_SEL_SET: assert property (sSelWr |=> pointerPairSelect == $past(dataWrData[0]))
    else $error("select bit not taken");
  AST_SEL_HOLD: assert property ($changed(pointerPairSelect) |-> $past(selWr))
    else $error("select bit moved alone");
endmodule
bind asd_address_space_decoder asd_dec_assertions chk (.*);

// ### sim/asd_address_space_decoder_tb_top.sv
// Purpose: Directed test of fetch steering, data routing and pointers
// Assumes: Lock input low until the last test
// Notes: Other-register read data is inverted unless an outside register is expected
module asd_address_space_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import asd_pkg::*;
  logic core_clk, rst, externalFetchStrap, lockBitOne, fetchReq, dataReq, dataWr, dataIndirect, dataStack;
  logic extMoveReq, fetchInternal, fetchExternal, dataValid, regAccess, regWrite, upperRamHit, extMoveValid;
  logic pointerPairSelect;
  logic [15:0] fetchAddr, fetchAddrOut, extMoveAddr, extHits;
  logic [7:0] dataAddr, dataWrData, otherRegRdData, dataRdData, regAddr, regWrData, port2Addr;
  int err_count = 0;
  int check_count = 0;
  asd_address_space_decoder dut (.*);
  asd_ext_mem_model mem (.*);
  // Free-running core clock
  initial
  begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // Request held one edge, answer sampled after the next
  task automatic fetch(input logic [15:0] a, input logic eInt);
    @(posedge core_clk);
    fetchReq <= 1'h1;
    fetchAddr <= a;
    @(posedge core_clk);
    fetchReq <= 1'h0;
    #1;
    chk("fetch", {14'h0, eInt, !eInt}, {14'h0, fetchInternal, fetchExternal});
    chk("fetchAddrOut", a, fetchAddrOut);
  endtask
  // Route is {register, upper RAM}
  task automatic acc(input logic w, ind, stk, input logic [7:0] a, d, eRd, input logic [1:0] eRt);
    @(posedge core_clk);
    dataReq <= 1'h1;
    dataWr <= w;
    dataIndirect <= ind;
    dataStack <= stk;
    dataAddr <= a;
    dataWrData <= d;
    otherRegRdData <= eRt[1] ? eRd : ~eRd;
    @(posedge core_clk);
    dataReq <= 1'h0;
    #1;
    chk("dataValid", 16'h0001, {15'h0, dataValid});
    chk("dataRdData", {8'h00, eRd}, {8'h00, dataRdData});
    chk("route", {14'h0, eRt}, {14'h0, regAccess, upperRamHit});
    chk("regWrite", {15'h0, eRt[1] & w}, {15'h0, regWrite});
    chk("regCopy", {a, d}, {regAddr, regWrData});
  endtask
  task automatic mv(input logic [15:0] e);
    @(posedge core_clk);
    extMoveReq <= 1'h1;
    @(posedge core_clk);
    extMoveReq <= 1'h0;
    #1;
    chk("extMoveValid", 16'h0001, {15'h0, extMoveValid});
    chk("extMoveAddr", e, extMoveAddr);
    chk("port2Addr", {8'h00, e[15:8]}, {8'h00, port2Addr});
  endtask
  task automatic pulse_rst;
    rst <= 1'h1;
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Whole run is about 70 cycles
  initial
  begin
    #50us;
    err_count++;
    results;
  end
  initial
  begin
    {rst, fetchReq, dataReq, dataWr, dataIndirect, dataStack, extMoveReq, lockBitOne} = 8'h80;
    externalFetchStrap = 1'h1;
    {fetchAddr, dataAddr, dataWrData, otherRegRdData} = 40'h0;
    pulse_rst;
    acc(0, 0, 0, 8'hA2, 8'h00, 8'h00, 2'h0);
    fetch(16'h0000, 1);
    fetch(16'h1FFF, 1);
    fetch(16'h2000, 0);
    fetch(16'hFFFF, 0);
    @(posedge core_clk);
    externalFetchStrap <= 1'h0;
    fetch(16'h0000, 0);
    fetch(16'h1FFF, 0);
    // The model counts the last answer on the edge after it stands
    @(posedge core_clk);
    #1;
    chk("extHits", 16'h0004, extHits);
    $display("test fetch done");
    acc(1, 0, 0, 8'h00, 8'h5A, 8'h00, 2'h0);
    acc(1, 1, 0, 8'hA0, 8'hC3, 8'h00, 2'h1);
    acc(1, 0, 1, 8'hFF, 8'h99, 8'h00, 2'h1);
    acc(0, 1, 0, 8'h00, 8'h00, 8'h5A, 2'h0);
    acc(0, 0, 0, 8'hA0, 8'h00, 8'h77, 2'h2);
    acc(1, 0, 0, 8'hA0, 8'h3C, 8'h00, 2'h2);
    acc(0, 0, 1, 8'hA0, 8'h00, 8'hC3, 2'h1);
    acc(0, 1, 0, 8'hFF, 8'h00, 8'h99, 2'h1);
    $display("test data done");
    acc(1, 0, 0, 8'h82, 8'h34, 8'h00, 2'h0);
    acc(1, 0, 0, 8'h83, 8'h12, 8'h00, 2'h0);
    acc(1, 0, 0, 8'h84, 8'h78, 8'h00, 2'h0);
    acc(1, 0, 0, 8'h85, 8'h56, 8'h00, 2'h0);
    mv(16'h1234);
    acc(1, 0, 0, 8'hA2, 8'hFF, 8'h00, 2'h0);
    acc(0, 0, 0, 8'hA2, 8'h00, 8'h01, 2'h0);
    chk("pointerPairSelect", 16'h0001, {15'h0, pointerPairSelect});
    mv(16'h5678);
    $display("test pointer done");
    @(posedge core_clk);
    lockBitOne <= 1'h1;
    externalFetchStrap <= 1'h1;
    pulse_rst;
    externalFetchStrap <= 1'h0;
    fetch(16'h0000, 1);
    mv(16'h0000);
    $display("test lock done");
    results;
  end
endmodule
